// >>> verilog/plt_tile.sv
/*
  Programmable logic tile: four logic elements, the carry chain, the wide
  logic mux stage and four sequential elements, with control derivation.
  Assumes configuration inputs are held steady by the configuration logic
  and that tile clocks arrive as one-cycle enables synchronous to mclk.
*/

// Behaviour
// - Tile takes 58 inputs, drives nine outputs; 37 control inputs yield six controls.
// - Each element has a four-input table, one-bit adder and multiplier AND gate.
// - Element inputs a, b feed the table; c, d feed table or pass through.
// - Input e is memory write data, a mux select, or a pass-through.
// - Combinational tables realise any four-input function; wide stage builds wider ones.
// - Memory mode offers up to 64 bits in single and dual port shapes.
// - Distributed memory runs with clocked reads or asynchronous reads.
// - With any table in memory mode, set/reset is write enable; clock zero clocks synchronous memory only, asynchronous memory writes on every mclk.
// - Shift mode gives 1 to 8 bit shifters, cascadable to 32 bits.
// - Carry enters element three, ripples down, and leaves from element zero.
// - Adder sums reach sequential elements; carry out can feed sequential element zero.
// - Wide stage muxes build gates up to 16 inputs and 2:1 to 8:1 muxes.
module plt_tile (
  // Clock and reset.
  input  wire logic          mclk,
  input  wire logic          srst,
  // Fabric inputs.
  input  wire logic [19:0]   logic_in,
  input  wire logic [36:0]   ctrl_in,
  input  wire logic          carry_in,
  // Configuration.
  input  wire logic [35:0]   cfg_ctrl_sel,
  input  wire logic [15:0]   cfg_mode,
  input  wire logic [3:0]    cfg_booth,
  input  wire logic [3:0]    cfg_cascade,
  input  wire logic [1:0]    cfg_dual,
  input  wire logic [1:0]    cfg_deep,
  input  wire logic [63:0]   cfg_init,
  input  wire logic [11:0]   cfg_wide_sel,
  input  wire logic          cfg_gate_or,
  input  wire logic          cfg_carry_elem0,
  input  wire logic [3:0]    cfg_sr_val,
  // Tile outputs.
  output logic [3:0]         comb_out,
  output logic [3:0]         seq_out,
  output logic               carry_out
);

  // ---------------------------------------------------------------------------
  // Control derivation
  // ---------------------------------------------------------------------------
  logic [5:0] ctrl;
  logic       tick0;
  logic       tick1;
  logic       en_lo;
  logic       en_hi;
  logic       srwe;
  logic       load;
  logic       any_mem;
  logic       sr_act;
  logic       mem_we;

  // Each control signal picks one control input; codes past the last read zero.
  genvar gi;
  generate
    for (gi = 0; gi < plt_pkg::CTRL_SIGNALS; gi++) begin : g_ctrl
      logic [5:0] sel;
      assign sel      = cfg_ctrl_sel[gi*plt_pkg::CTRL_SEL_W +: plt_pkg::CTRL_SEL_W];
      assign ctrl[gi] = (sel < plt_pkg::CTRL_IN_LIMIT) ? ctrl_in[sel] : 1'b0;
    end
  endgenerate

  // Named controls used across the tile.
  assign tick0  = ctrl[plt_pkg::CTL_TICK_ZERO];
  assign tick1  = ctrl[plt_pkg::CTL_TICK_ONE];
  assign en_lo  = ctrl[plt_pkg::CTL_EN_LOW];
  assign en_hi  = ctrl[plt_pkg::CTL_EN_HIGH];
  assign srwe   = ctrl[plt_pkg::CTL_SRWE];
  assign load   = ctrl[plt_pkg::CTL_LOAD];
  assign mem_we = srwe & any_mem;
  assign sr_act = srwe & ~any_mem;

  // ---------------------------------------------------------------------------
  // Logic elements and carry chain
  // ---------------------------------------------------------------------------
  logic [3:0] lut;
  logic [3:0] sum;
  logic [3:0] cout;
  logic [3:0] is_mem;
  logic [3:0] e_in;
  logic [4:0] chain;

  assign any_mem   = |is_mem;
  assign chain[4]  = carry_in;
  assign chain[3:0] = cout;
  assign carry_out = cout[0];

  generate
    for (gi = 0; gi < plt_pkg::ELEM_COUNT; gi++) begin : g_elem
      plt_pkg::plt_mode_t mode;
      logic [4:0] in;
      logic [3:0] waddr;
      logic       wdata;
      logic       bank_ok;
      logic       sin;
      assign in       = logic_in[gi*plt_pkg::ELEM_INPUTS +: plt_pkg::ELEM_INPUTS];
      assign e_in[gi] = in[4];
      assign mode     = plt_pkg::plt_mode_t'(cfg_mode[gi*4 +: 4]);
      assign is_mem[gi] = (mode == plt_pkg::MODE_RAM_SYNC) || (mode == plt_pkg::MODE_RAM_ASYNC);
      // Odd element of a dual port pair writes with its partner's address and data.
      if (gi % 2 == 1) begin : g_odd
        assign waddr = cfg_dual[gi/2] ? logic_in[(gi-1)*5 +: 4] : in[3:0];
        assign wdata = (cfg_deep == plt_pkg::DEEP_64) ? e_in[0] :
                       (cfg_deep == plt_pkg::DEEP_32 || cfg_dual[gi/2]) ? e_in[gi-1] : in[4];
        assign sin   = cfg_cascade[gi] ? lut[gi-1] : in[4];
      end else begin : g_even
        assign waddr = in[3:0];
        assign wdata = (cfg_deep == plt_pkg::DEEP_64) ? e_in[0] : in[4];
        if (gi > 0) begin : g_casc
          assign sin = cfg_cascade[gi] ? lut[gi-1] : in[4];
        end else begin : g_first
          assign sin = in[4];
        end
      end
      // Deep memories steer a write to the element whose bank matches bit four (32 deep) or bits four and five (64 deep).
      assign bank_ok = (cfg_deep == plt_pkg::DEEP_32) ? (e_in[gi|1] == 1'(gi % 2)) :
                       (cfg_deep == plt_pkg::DEEP_64) ? ({e_in[2], e_in[gi|1]} == 2'(gi)) :
                       1'b1;
      plt_logic_element u_elem (
        .mclk     (mclk),
        .srst     (srst),
        .mode     (mode),
        .booth    (cfg_booth[gi]),
        .init     (cfg_init[gi*16 +: 16]),
        .load     (load),
        .in       (in),
        .cin      (chain[gi+1]),
        .shift_in (sin),
        .tick     (tick0),
        .we       (mem_we & bank_ok),
        .waddr    (waddr),
        .wdata    (wdata),
        .lut_out  (lut[gi]),
        .sum      (sum[gi]),
        .cout     (cout[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Wide logic mux stage
  // ---------------------------------------------------------------------------
  logic mux2_lo;
  logic mux2_hi;
  logic mux4;
  logic gate;

  // Pair muxes select on the odd elements' e inputs, the top mux on element two's.
  always_comb begin
    mux2_lo = e_in[1] ? lut[1] : lut[0];
    mux2_hi = e_in[3] ? lut[3] : lut[2];
    mux4    = e_in[2] ? mux2_hi : mux2_lo;
    gate    = cfg_gate_or ? (|lut) : (&lut);
  end

  // Per element output select; element zero can take the tile carry instead.
  generate
    for (gi = 0; gi < plt_pkg::ELEM_COUNT; gi++) begin : g_wide
      logic [2:0] sel;
      logic [4:0] in;
      assign sel = cfg_wide_sel[gi*plt_pkg::WIDE_SEL_W +: plt_pkg::WIDE_SEL_W];
      assign in  = logic_in[gi*plt_pkg::ELEM_INPUTS +: plt_pkg::ELEM_INPUTS];
      always_comb begin
        unique case (sel)
          plt_pkg::SEL_TABLE:  comb_out[gi] = lut[gi];
          plt_pkg::SEL_SUM:    comb_out[gi] = sum[gi];
          plt_pkg::SEL_PASS_C: comb_out[gi] = in[2];
          plt_pkg::SEL_PASS_D: comb_out[gi] = in[3];
          plt_pkg::SEL_PASS_E: comb_out[gi] = in[4];
          plt_pkg::SEL_MUX2:   comb_out[gi] = (gi < 2) ? mux2_lo : mux2_hi;
          plt_pkg::SEL_MUX4:   comb_out[gi] = mux4;
          plt_pkg::SEL_GATE:   comb_out[gi] = gate;
        endcase
        if (gi == 0 && cfg_carry_elem0) begin
          comb_out[gi] = carry_out;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Sequential elements
  // ---------------------------------------------------------------------------
  logic [3:0] next_seq;

  // Elements zero and one run on clock zero, two and three on clock one.
  generate
    for (gi = 0; gi < plt_pkg::ELEM_COUNT; gi++) begin : g_seq
      logic tk;
      logic en;
      assign tk = (gi < 2) ? tick0 : tick1;
      assign en = (gi < 2) ? en_lo : en_hi;
      always_comb begin
        next_seq[gi] = seq_out[gi];
        if (tk && sr_act) begin
          next_seq[gi] = cfg_sr_val[gi];
        end else if (tk && en) begin
          next_seq[gi] = comb_out[gi];
        end
      end
    end
  endgenerate

  // Sequential element registers.
  always_ff @(posedge mclk) begin
    if (srst) begin
      seq_out <= {plt_pkg::ELEM_COUNT{plt_pkg::BIT_RESET}};
    end else begin
      seq_out <= next_seq;
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  logic [3:0] prop;
  logic [1:0] mux_idx;

  assign prop    = sum ^ chain[4:1];
  assign mux_idx = {e_in[2], e_in[2] ? e_in[3] : e_in[1]};

  property p_carry_prop;
    @(posedge mclk) disable iff (srst) (&prop) |-> (carry_out == carry_in);
  endproperty
  a_carry_prop: assert property (p_carry_prop) else $error("carry did not ripple");

  property p_seq_capture;
    @(posedge mclk) disable iff (srst)
      (tick0 && en_lo && !sr_act) |=> (seq_out[0] == $past(comb_out[0]));
  endproperty
  a_seq_capture: assert property (p_seq_capture) else $error("sequential capture wrong");

  property p_carry_elem0;
    @(posedge mclk) disable iff (srst)
      (cfg_carry_elem0 && tick0 && en_lo && !sr_act) |=> (seq_out[0] == $past(carry_out));
  endproperty
  a_carry_elem0: assert property (p_carry_elem0) else $error("carry not at element zero");

  property p_mux4;
    @(posedge mclk) disable iff (srst)
      (cfg_wide_sel[2:0] == plt_pkg::SEL_MUX4 && !cfg_carry_elem0) |-> (comb_out[0] == lut[mux_idx]);
  endproperty
  a_mux4: assert property (p_mux4) else $error("wide mux picked wrong input");

  property p_gate;
    @(posedge mclk) disable iff (srst)
      (cfg_wide_sel[5:3] == plt_pkg::SEL_GATE && !cfg_gate_or) |-> (comb_out[1] == (&lut));
  endproperty
  a_gate: assert property (p_gate) else $error("wide gate wrong");

  property p_pass_c;
    @(posedge mclk) disable iff (srst)
      (cfg_wide_sel[2:0] == plt_pkg::SEL_PASS_C && !cfg_carry_elem0 && tick0 && en_lo && !sr_act)
        |=> (seq_out[0] == $past(logic_in[2]));
  endproperty
  a_pass_c: assert property (p_pass_c) else $error("pass-through c lost");

  property p_sr_reset;
    @(posedge mclk) disable iff (srst)
      (tick1 && sr_act) |=> (seq_out[3:2] == $past(cfg_sr_val[3:2]));
  endproperty
  a_sr_reset: assert property (p_sr_reset) else $error("set/reset not applied");

  c_carry_through: cover property (@(posedge mclk) disable iff (srst) (&prop) && carry_in);
  c_cascade: cover property (@(posedge mclk) disable iff (srst) (&cfg_cascade[3:1]) && tick0);
  c_mem_write: cover property (@(posedge mclk) disable iff (srst) mem_we && tick0);

endmodule // plt_tile

// >>> verilog/plt_pkg.sv
/*
  Package for the programmable logic tile: table modes, wide stage selects,
  control signal indices, sizes and reset values.
  Assumes it is compiled before every other file of the tile.
*/
package plt_pkg;

  // ---------------------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------------------
  localparam int ELEM_COUNT      = 4;
  localparam int ELEM_INPUTS     = 5;
  localparam int LOGIC_INPUTS    = 20;
  localparam int CTRL_INPUTS     = 37;
  localparam int CTRL_SIGNALS    = 6;
  localparam int TABLE_DEPTH     = 16;
  localparam int SHIFT_LEN       = 8;
  localparam int CTRL_SEL_W      = 6;
  localparam int WIDE_SEL_W      = 3;
  localparam logic [5:0] CTRL_IN_LIMIT = 6'h25;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [15:0] TABLE_RESET = 16'h0000;
  localparam logic        BIT_RESET   = 1'b0;

  // ---------------------------------------------------------------------------
  // Indices of the six derived control signals
  // ---------------------------------------------------------------------------
  localparam int CTL_TICK_ZERO = 0;
  localparam int CTL_TICK_ONE  = 1;
  localparam int CTL_EN_LOW    = 2;
  localparam int CTL_EN_HIGH   = 3;
  localparam int CTL_SRWE      = 4;
  localparam int CTL_LOAD      = 5;

  // ---------------------------------------------------------------------------
  // Wide stage output selects
  // ---------------------------------------------------------------------------
  localparam logic [2:0] SEL_TABLE  = 3'h0;
  localparam logic [2:0] SEL_SUM    = 3'h1;
  localparam logic [2:0] SEL_PASS_C = 3'h2;
  localparam logic [2:0] SEL_PASS_D = 3'h3;
  localparam logic [2:0] SEL_PASS_E = 3'h4;
  localparam logic [2:0] SEL_MUX2   = 3'h5;
  localparam logic [2:0] SEL_MUX4   = 3'h6;
  localparam logic [2:0] SEL_GATE   = 3'h7;

  // ---------------------------------------------------------------------------
  // Memory depth options
  // ---------------------------------------------------------------------------
  localparam logic [1:0] DEEP_16 = 2'h0;
  localparam logic [1:0] DEEP_32 = 2'h1;
  localparam logic [1:0] DEEP_64 = 2'h2;

  // Table modes of one logic element.
  typedef enum logic [3:0] {
    MODE_COMB      = 4'h1,
    MODE_RAM_SYNC  = 4'h2,
    MODE_RAM_ASYNC = 4'h4,
    MODE_SHIFT     = 4'h8
  } plt_mode_t;

endpackage

// >>> verilog/plt_logic_element.sv
/*
  One logic element: a sixteen entry table used as function, memory or shift
  register, a one-bit full adder and the multiplier AND gate.
  Assumes the tile supplies the write address, write data, write enable and
  the tile clock zero enable already qualified for this element.
*/
module plt_logic_element (
  // Clock and reset.
  input  wire logic              mclk,
  input  wire logic              srst,
  // Configuration.
  input  plt_pkg::plt_mode_t     mode,
  input  wire logic              booth,
  input  wire logic [15:0]       init,
  input  wire logic              load,
  // Operands a, b, c, d, e in bits zero to four.
  input  wire logic [4:0]        in,
  input  wire logic              cin,
  input  wire logic              shift_in,
  // Memory write side.
  input  wire logic              tick,
  input  wire logic              we,
  input  wire logic [3:0]        waddr,
  input  wire logic              wdata,
  // Results.
  output logic                   lut_out,
  output logic                   sum,
  output logic                   cout
);

  logic [15:0] table_q;
  logic [15:0] next_table;
  logic        rd_q;
  logic        next_rd;
  logic [3:0]  raddr;
  logic        op_b;
  logic        rd_now;
  logic [6:0]  shift_low;

  assign raddr     = in[3:0];
  assign rd_now    = table_q[raddr];
  assign shift_low = table_q[6:0];

  // Table update for load, memory writes and shifting.
  always_comb begin
    next_table = table_q;
    next_rd    = rd_q;
    if (load) begin
      next_table = init;
    end else begin
      unique case (mode)
        plt_pkg::MODE_COMB: begin
        end
        plt_pkg::MODE_RAM_SYNC: begin
          if (tick) begin
            next_rd = table_q[raddr];
            if (we) begin
              next_table[waddr] = wdata;
            end
          end
        end
        plt_pkg::MODE_RAM_ASYNC: begin
          if (we) begin
            next_table[waddr] = wdata;
          end
        end
        plt_pkg::MODE_SHIFT: begin
          if (tick) begin
            next_table[7:0] = {table_q[6:0], shift_in};
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Table and read registers.
  always_ff @(posedge mclk) begin
    if (srst) begin
      table_q <= plt_pkg::TABLE_RESET;
      rd_q    <= plt_pkg::BIT_RESET;
    end else begin
      table_q <= next_table;
      rd_q    <= next_rd;
    end
  end

  // Table output: registered read, shift tap or direct lookup.
  always_comb begin
    if (mode == plt_pkg::MODE_RAM_SYNC) begin
      lut_out = rd_q;
    end else if (mode == plt_pkg::MODE_SHIFT) begin
      lut_out = table_q[{1'b0, in[2:0]}];
    end else begin
      lut_out = table_q[raddr];
    end
  end

  // Full adder, with the AND gate optionally replacing operand b.
  assign op_b = booth ? (in[2] & in[3]) : in[1];
  assign sum  = in[0] ^ op_b ^ cin;
  assign cout = (in[0] & op_b) | (cin & (in[0] ^ op_b));

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  property p_adder;
    @(posedge mclk) disable iff (srst)
      {cout, sum} == (2'(in[0]) + 2'(op_b) + 2'(cin));
  endproperty
  a_adder: assert property (p_adder) else $error("adder result wrong");

  property p_sync_read;
    @(posedge mclk) disable iff (srst)
      (mode == plt_pkg::MODE_RAM_SYNC && tick && !load) |=> (rd_q == $past(rd_now));
  endproperty
  a_sync_read: assert property (p_sync_read) else $error("sync read not registered");

  property p_shift;
    @(posedge mclk) disable iff (srst)
      (mode == plt_pkg::MODE_SHIFT && tick && !load)
        |=> (table_q[0] == $past(shift_in)) && (table_q[7:1] == $past(shift_low));
  endproperty
  a_shift: assert property (p_shift) else $error("shift step wrong");

  property p_write;
    @(posedge mclk) disable iff (srst)
      (mode == plt_pkg::MODE_RAM_ASYNC && we && !load) |=> (table_q[$past(waddr)] == $past(wdata));
  endproperty
  a_write: assert property (p_write) else $error("memory write lost");

  property p_no_write;
    @(posedge mclk) disable iff (srst)
      ((mode == plt_pkg::MODE_RAM_ASYNC || mode == plt_pkg::MODE_RAM_SYNC) && !we && !load)
        |=> $stable(table_q);
  endproperty
  a_no_write: assert property (p_no_write) else $error("memory changed without write enable");

  c_sync_write: cover property (@(posedge mclk) disable iff (srst)
    mode == plt_pkg::MODE_RAM_SYNC && tick && we);

endmodule // plt_logic_element

// >>> tb/plt_fabric.sv
/*
  Routing fabric model for the logic tile: places six control requests on the
  control inputs and passes a neighbour's carry into the tile.
  Assumes the tile selects control i from input 30 + i.
*/
module plt_fabric (
  // Clock.
  input  wire logic        mclk,
  // Requests from the bench.
  input  wire logic [5:0]  ctl,
  input  wire logic        carry_req,
  // Tile side.
  output logic [36:0]      ctrl_in,
  output logic             carry_in
);
  timeunit 1ns;
  timeprecision 1ps;

  logic noise;

  // Unselected lines toggle every cycle so a wrong select shows up.
  initial noise = 1'b0;
  always @(posedge mclk) begin
    noise <= ~noise;
  end

  // Controls sit on lines 30 to 35; the neighbour's carry passes straight on.
  assign ctrl_in  = {noise, ctl, {30{~noise}}};
  assign carry_in = carry_req;
endmodule  // plt_fabric

// >>> tb/tb.sv
/*
  Self-checking bench for the logic tile, one task per scenario.
  Assumes plt_pkg, the tile and the fabric model are compiled first.
*/
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin n_fail++; \
  $display("unexpected %s: expected %h, seen %h", nm, ex, got); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------------------
  // Signals and instances
  // ---------------------------------------------------------------------------
  localparam logic [3:0] M_COMB  = plt_pkg::MODE_COMB;
  localparam logic [3:0] M_SYNC  = plt_pkg::MODE_RAM_SYNC;
  localparam logic [3:0] M_ASYNC = plt_pkg::MODE_RAM_ASYNC;
  localparam logic [3:0] M_SHIFT = plt_pkg::MODE_SHIFT;
  localparam logic [7:0] PAT     = 8'hb2;
  logic        mclk, srst, carry_req, carry_in, carry_out, cfg_gate_or, cfg_carry_elem0;
  logic [1:0]  cfg_deep, cfg_dual;
  logic [19:0] logic_in;
  logic [36:0] ctrl_in;
  logic [5:0]  ctl;
  logic [15:0] cfg_mode;
  logic [63:0] cfg_init;
  logic [11:0] cfg_wide_sel;
  logic [3:0]  cfg_booth, cfg_cascade, cfg_sr_val, comb_out, seq_out;
  int          n_fail, tests_run;

  // Fabric model in front of the tile.
  plt_fabric fabric (.mclk(mclk), .ctl(ctl), .carry_req(carry_req), .ctrl_in(ctrl_in), .carry_in(carry_in));

  // Tile under test; controls i = 0..5 come from lines 30..35.
  plt_tile DUT (
    .mclk(mclk), .srst(srst), .logic_in(logic_in), .ctrl_in(ctrl_in), .carry_in(carry_in),
    .cfg_ctrl_sel({6'h23, 6'h22, 6'h21, 6'h20, 6'h1f, 6'h1e}), .cfg_mode(cfg_mode),
    .cfg_booth(cfg_booth), .cfg_cascade(cfg_cascade), .cfg_dual(cfg_dual), .cfg_deep(cfg_deep),
    .cfg_init(cfg_init), .cfg_wide_sel(cfg_wide_sel), .cfg_gate_or(cfg_gate_or),
    .cfg_carry_elem0(cfg_carry_elem0), .cfg_sr_val(cfg_sr_val), .comb_out(comb_out),
    .seq_out(seq_out), .carry_out(carry_out));

  // Clock of 5 ns period.
  initial mclk = 1'b0;
  always begin
    #2.5 mclk = ~mclk;
  end

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  // Prints the verdict and ends the run.
  task automatic test_done();
    if (n_fail == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Drives operands with controls for one edge, then settles to the falling edge.
  task automatic pulse(input logic [19:0] li, input logic [5:0] c);
    @(posedge mclk);
    logic_in <= li;
    ctl      <= c;
    @(posedge mclk);
    ctl <= 6'h00;
    @(negedge mclk);
  endtask

  // Sets modes and table contents through the load strobe.
  task automatic load(input logic [15:0] m, input logic [63:0] v);
    @(posedge mclk);
    cfg_mode     <= m;
    cfg_init     <= v;
    cfg_wide_sel <= 12'h000;
    cfg_booth    <= 4'h0;
    cfg_carry_elem0 <= 1'b0;
    pulse(20'h00000, 6'h20);
  endtask

  // Ripple sum of the four elements, element three taking the carry first.
  function automatic logic [4:0] add_exp(input logic [19:0] li, input logic ci, input logic [3:0] bo);
    logic       c;
    logic       b;
    logic [4:0] r;
    c = ci;
    r = 5'h00;
    for (int k = 3; k >= 0; k--) begin
      b    = bo[k] ? (li[5*k+2] & li[5*k+3]) : li[5*k+1];
      r[k] = li[5*k] ^ b ^ c;
      c    = (li[5*k] & b) | (li[5*k] & c) | (b & c);
    end
    r[4] = c;
    return r;
  endfunction

  // Shifts eight bits into element zero, with the taps of elements zero and one at seven.
  task automatic shift8(input logic [7:0] p);
    for (int i = 0; i < 8; i++) begin
      pulse({12'h0, 3'h7, p[i], 4'h7}, 6'h01);
    end
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  // Parity and four-input AND tables over all addresses.
  task automatic t_comb();
    load({4{M_COMB}}, {32'h0, 16'h8000, 16'h6996});
    for (int j = 0; j < 16; j++) begin
      pulse({11'h0, j[3:0], 1'b0, j[3:0]}, 6'h00);
      `CHK("comb0", ^j[3:0], comb_out[0])
      `CHK("comb1", j == 15, comb_out[1])
    end
  endtask

  // Carry chain sums over many operands, optionally with multiplier gates.
  task automatic t_carry(input logic [3:0] bo);
    logic [19:0] li;
    logic [4:0]  ex;
    @(posedge mclk);
    cfg_booth    <= bo;
    cfg_carry_elem0 <= bo[0];
    cfg_wide_sel <= {4{plt_pkg::SEL_SUM}};
    for (int i = 0; i < 1024; i++) begin
      li = {i[9:0], i[9:0]} ^ 20'h5a3c6;
      @(posedge mclk);
      logic_in  <= li;
      carry_req <= i[3] ^ i[7];
      @(negedge mclk);
      ex = add_exp(li, i[3] ^ i[7], bo);
      `CHK("carry_out", ex[4], carry_out)
      `CHK("sum", bo[0] ? {ex[3:1], ex[4]} : ex[3:0], comb_out)
    end
  endtask

  // Pass-through operands, set/reset, capture and hold of sequential elements.
  task automatic t_seq();
    load({4{M_COMB}}, 64'h0);
    @(posedge mclk);
    cfg_wide_sel <= {plt_pkg::SEL_PASS_C, plt_pkg::SEL_PASS_E, plt_pkg::SEL_PASS_D, plt_pkg::SEL_PASS_C};
    cfg_sr_val   <= 4'ha;
    pulse(20'h04004, 6'h13);
    `CHK("pass", 4'h5, comb_out)
    `CHK("seq_sr", 4'ha, seq_out)
    pulse(20'h04004, 6'h0f);
    `CHK("seq_cap", 4'h5, seq_out)
    pulse(20'hfbffb, 6'h03);
    `CHK("seq_hold", 4'h5, seq_out)
  endtask

  // Synchronous memory: clocked write and read, write enable without clock.
  task automatic t_sync();
    load({{3{M_COMB}}, M_SYNC}, 64'hf0f0);
    pulse(20'h00013, 6'h11);
    `CHK("ram_old", 1'b0, comb_out[0])
    `CHK("seq_we", 4'h5, seq_out)
    pulse(20'h00003, 6'h01);
    `CHK("ram_new", 1'b1, comb_out[0])
    pulse(20'h00000, 6'h00);
    `CHK("ram_held", 1'b1, comb_out[0])
    pulse(20'h00012, 6'h10);
    pulse(20'h00002, 6'h01);
    `CHK("ram_notick", 1'b0, comb_out[0])
    pulse(20'h00004, 6'h01);
    `CHK("ram_init", 1'b1, comb_out[0])
  endtask

  // Asynchronous memory: write on enable, combinational read.
  task automatic t_async();
    load({{3{M_COMB}}, M_ASYNC}, 64'h0);
    pulse(20'h00016, 6'h10);
    `CHK("async_wr", 1'b1, comb_out[0])
    pulse(20'h00007, 6'h00);
    `CHK("async_rd", 1'b0, comb_out[0])
    pulse(20'h00006, 6'h10);
    `CHK("async_clr", 1'b0, comb_out[0])
  endtask

  // Shift registers in elements zero and one, one cascaded from the other.
  task automatic t_shift();
    load({{2{M_COMB}}, M_SHIFT, M_SHIFT}, 64'h0);
    shift8(PAT);
    for (int j = 0; j < 8; j++) begin
      pulse({17'h0, j[2:0]}, 6'h00);
      `CHK("shift0", PAT[7-j], comb_out[0])
    end
    shift8(8'h00);
    for (int j = 0; j < 8; j++) begin
      pulse({12'h0, j[2:0], 5'h0}, 6'h00);
      `CHK("shift1", PAT[7-j], comb_out[1])
    end
  endtask

  // Wide stage: four-way multiplexer and wide AND/OR gate.
  task automatic t_wide();
    load({4{M_COMB}}, {16'hffff, 16'h0, 16'hffff, 16'h0});
    @(posedge mclk);
    cfg_wide_sel <= {plt_pkg::SEL_MUX2, 6'h0, plt_pkg::SEL_MUX4};
    for (int m = 0; m < 8; m++) begin
      pulse({m[2], 4'h0, m[1], 4'h0, m[0], 9'h0}, 6'h00);
      `CHK("mux4", m[1] ? m[2] : m[0], comb_out[0])
      `CHK("mux2", m[2], comb_out[3])
    end
    load({4{M_COMB}}, {4{16'h8000}});
    @(posedge mclk);
    cfg_wide_sel <= {4{plt_pkg::SEL_GATE}};
    pulse(20'h7bdef, 6'h00);
    `CHK("gate_and", 4'hf, comb_out)
    pulse(20'h7bdee, 6'h00);
    `CHK("gate_and0", 4'h0, comb_out)
    @(posedge mclk);
    cfg_gate_or <= 1'b1;
    pulse(20'h0000f, 6'h00);
    `CHK("gate_or", 4'hf, comb_out)
  endtask

  // Deep and dual-port memory: one 64x1 array read through the 4:1 mux, then a
  // 16x1 dual-port pair whose odd table follows its partner's write address.
  task automatic t_deep();
    logic [5:0] a;
    logic       d;
    load({4{M_ASYNC}}, 64'h0);
    @(posedge mclk);
    cfg_deep     <= plt_pkg::DEEP_64;
    cfg_wide_sel <= {9'h0, plt_pkg::SEL_MUX4};
    for (int w = 0; w < 8; w++) begin
      a = {w[1:0], 4'h5};
      d = (w == 2);
      pulse({a[4], a[3:0], a[5], a[3:0], a[4], a[3:0], d, a[3:0]}, (w < 4) ? 6'h10 : 6'h00);
      if (w >= 4) `CHK("deep64", w[1:0] == 2'h2, comb_out[0])
    end
    @(posedge mclk);
    cfg_deep     <= plt_pkg::DEEP_16;
    cfg_dual     <= 2'h1;
    cfg_wide_sel <= 12'h000;
    pulse(20'h00019, 6'h10);
    pulse(20'h00120, 6'h00);
    `CHK("dual_rd", 1'b1, comb_out[1])
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  // Resets the tile, runs every scenario and reports.
  initial begin
    {srst, carry_req, cfg_gate_or, cfg_carry_elem0} = 4'h8;
    {logic_in, ctl, cfg_mode, cfg_init, cfg_wide_sel, cfg_deep, cfg_dual} = '0;
    {cfg_booth, cfg_sr_val, n_fail, tests_run} = '0;
    cfg_cascade = 4'he;
    repeat (10) @(posedge mclk);
    srst <= 1'b0;
    @(negedge mclk);
    `CHK("seq_reset", 4'h0, seq_out)
    `CHK("comb_reset", 4'h0, comb_out)
    t_comb();
    t_carry(4'h0);
    t_carry(4'hf);
    t_seq();
    t_sync();
    t_async();
    t_shift();
    t_wide();
    t_deep();
    test_done();
  end

  // Cuts a hung run short.
  initial begin
    repeat (100000) @(posedge mclk);
    n_fail++;
    test_done();
  end
endmodule  // tb
